// File: include/dfs_pkg.sv
// Shared constants and types of the diagnostic and fault sense logic.
package dfs_pkg;

  // System clock rate.
  localparam int unsigned CLK_HZ = 20_000_000;

  // Default retry delay in clock cycles; a top parameter can shorten it.
  localparam int unsigned RETRY_CYCLES_DEF = 2000;
  localparam int unsigned RETRY_CNT_W = 16;

  // Register byte addresses on the APB.
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h00C;

  // Register decode result.
  typedef enum logic [2:0] {
    RS_NONE   = 3'h0,
    RS_CTRL   = 3'h1,
    RS_STATUS = 3'h2,
    RS_ISTAT  = 3'h3,
    RS_IMASK  = 3'h4
  } dfs_regsel_type;

  // Control register fields.
  localparam int unsigned CTRL_W = 1;
  localparam int unsigned CTRL_REGULATE_BIT = 0;
  localparam logic [0:0] CTRL_RESET = 1'h0;

  // Status register fields.
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_SWITCH_BIT = 2;
  localparam int unsigned STAT_LIMIT_BIT = 3;
  localparam int unsigned STAT_OFFSTATE_BIT = 4;
  localparam int unsigned STAT_FAULT_BIT = 5;
  localparam int unsigned STAT_DETEN_BIT = 6;

  // Interrupt status and mask fields.
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_SHUTDOWN_BIT = 0;
  localparam int unsigned IRQ_LIMIT_BIT = 1;
  localparam int unsigned IRQ_OFFSTATE_BIT = 2;
  localparam int unsigned IRQ_RETRY_BIT = 3;

  // Positions of the synchronised pin inputs.
  localparam int unsigned PIN_W = 10;
  localparam int unsigned PIN_EN = 0;
  localparam int unsigned PIN_DIAG = 1;
  localparam int unsigned PIN_SEL_HI = 2;
  localparam int unsigned PIN_SEL_LO = 3;
  localparam int unsigned PIN_LATCH = 4;
  localparam int unsigned PIN_OVERCUR = 5;
  localparam int unsigned PIN_THERMAL = 6;
  localparam int unsigned PIN_ENERGY = 7;
  localparam int unsigned PIN_ABOVE_OPENLOAD = 8;
  localparam int unsigned PIN_NEAR_SUPPLY = 9;

  // Sense select codes.
  localparam logic [1:0] SEL_LOAD = 2'h0;
  localparam logic [1:0] SEL_UNUSED = 2'h1;
  localparam logic [1:0] SEL_TEMP = 2'h2;
  localparam logic [1:0] SEL_SUPPLY = 2'h3;

  // Switch state, Gray coded along idle, active, fault, retry.
  typedef enum logic [1:0] {
    S_IDLE   = 2'h0,
    S_ACTIVE = 2'h1,
    S_FAULT  = 2'h3,
    S_RETRY  = 2'h2
  } dfs_state_type;

  // What the analog sense output carries.
  typedef enum logic [2:0] {
    RT_OFF    = 3'h0,
    RT_LOAD   = 3'h1,
    RT_TEMP   = 3'h2,
    RT_SUPPLY = 3'h3,
    RT_FAULT  = 3'h4
  } dfs_route_type;

endpackage

// File: design/dfs_pin_sync.sv
// Two-stage synchroniser for the asynchronous pin inputs.
`timescale 1ns/10ps
`default_nettype none
module dfs_pin_sync (
  input  wire logic                       clk_sys,
  input  wire logic                       resetn,
  input  wire logic [dfs_pkg::PIN_W-1:0]  pin_async,
  output logic      [dfs_pkg::PIN_W-1:0]  pin_sync
);

  typedef struct packed {
    logic [dfs_pkg::PIN_W-1:0] stage1;
    logic [dfs_pkg::PIN_W-1:0] stage2;
  } dfs_sync_type;

  dfs_sync_type cur_ff;
  dfs_sync_type nxt_ff;

  // The first stage feeds only the second, so metastability stays here.
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.stage1 = pin_async;
    nxt_ff.stage2 = cur_ff.stage1;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign pin_sync = cur_ff.stage2;

endmodule // dfs_pin_sync
`default_nettype wire

// File: design/dfs_retry_timer.sv
// Retry delay counter started at each shutdown.
`timescale 1ns/10ps
`default_nettype none
module dfs_retry_timer #(
  parameter int unsigned TERMINAL = dfs_pkg::RETRY_CYCLES_DEF
) (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic start,
  output logic      done
);

  typedef struct packed {
    logic [dfs_pkg::RETRY_CNT_W-1:0] count;
    logic                            expired;
  } dfs_timer_type;

  localparam logic [dfs_pkg::RETRY_CNT_W-1:0] LAST =
    dfs_pkg::RETRY_CNT_W'(TERMINAL - 1);

  dfs_timer_type cur_ff;
  dfs_timer_type nxt_ff;

  // A restart while counting begins the delay again from zero.
  always_comb begin
    nxt_ff = cur_ff;
    if (start) begin
      nxt_ff.count = '0;
      nxt_ff.expired = 1'b0;
    end else if (!cur_ff.expired) begin
      if (cur_ff.count == LAST) begin
        nxt_ff.expired = 1'b1;
      end else begin
        nxt_ff.count = cur_ff.count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign done = cur_ff.expired;

endmodule // dfs_retry_timer
`default_nettype wire

// File: design/dfs_diag_fault_sense.sv
// Fault handling, off-state detection and sense mux with APB registers.
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
//
// Contract
// - Regulating variant limits current, trips on energy/thermal.
// - After retry, hold sense fault until output rises.
// - Release status output as soon as retry re-enables.
// - Output never rising keeps sense fault asserted.
// - Off-state: output above threshold signals sense fault.
// - Off-state detection only with diag high, enable low.
// - Off-state faults only at select 00, never enabled.
// - Off-state indication follows comparator continuously.
// - Clear on diag falling or enable rising edge.
// - Select routes load, temperature, supply; else high-z.
// - Status output released without fault, low with fault.
// - Fault level only at select 00; others keep measuring.
// - Shutdown faults on status regardless of select, diag.
// - Fault detect: shutdown wait, limiting, off-state fault.
// - Thermal, current, energy shutdown and limiting are faults.
// - Latch input high keeps switch off after overcurrent.
// - Leave fault when clear, unlatched, timer expired.
module dfs_diag_fault_sense #(
  parameter int unsigned RETRY_CYCLES = dfs_pkg::RETRY_CYCLES_DEF
) (
  input  wire logic                         clk_sys,
  input  wire logic                         resetn,
  input  wire logic                         switch_enable,
  input  wire logic                         diag_enable,
  input  wire logic                         sense_select_hi,
  input  wire logic                         sense_select_lo,
  input  wire logic                         latch_mode,
  input  wire logic                         overcurrent_trip,
  input  wire logic                         thermal_trip,
  input  wire logic                         energy_trip,
  input  wire logic                         vout_above_openload,
  input  wire logic                         vout_near_supply,
  output logic                              switch_on,
  output logic                              current_limit_active,
  output logic                              offstate_detect_en,
  output logic                              open_load_flag,
  output logic                              sense_output_en,
  output dfs_pkg::dfs_route_type            sense_output,
  output logic                              fault_status_n_o,
  output logic                              fault_status_n_oe,
  output logic                              irq,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [dfs_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic [31:0]                       prdata,
  output logic                              pready,
  output logic                              pslverr
);

  typedef struct packed {
    dfs_pkg::dfs_state_type       state;
    logic                         prev_en;
    logic                         prev_diag;
    logic                         switch_on;
    logic                         limiting;
    logic                         det_en;
    logic                         offstate;
    logic                         fault_low;
    dfs_pkg::dfs_route_type       route;
    logic [dfs_pkg::CTRL_W-1:0]   ctrl;
    logic [dfs_pkg::IRQ_W-1:0]    irq_stat;
    logic [dfs_pkg::IRQ_W-1:0]    irq_mask;
    logic [31:0]                  rdata;
    logic                         err;
    logic                         irq;
  } dfs_core_type;

  dfs_core_type cur_ff;
  dfs_core_type nxt_ff;

  logic [dfs_pkg::PIN_W-1:0] pin_raw;
  logic [dfs_pkg::PIN_W-1:0] pin;
  logic                      timer_start;
  logic                      timer_done;

  // Register decode, shared by read data, read clear and error answer.
  function automatic dfs_pkg::dfs_regsel_type dfs_decode(
    input logic [dfs_pkg::ADDR_W-1:0] addr
  );
    dfs_pkg::dfs_regsel_type sel;
    case (addr)
      dfs_pkg::ADDR_CTRL: begin
        sel = dfs_pkg::RS_CTRL;
      end
      dfs_pkg::ADDR_STATUS: begin
        sel = dfs_pkg::RS_STATUS;
      end
      dfs_pkg::ADDR_IRQ_STAT: begin
        sel = dfs_pkg::RS_ISTAT;
      end
      dfs_pkg::ADDR_IRQ_MASK: begin
        sel = dfs_pkg::RS_IMASK;
      end
      default: begin
        sel = dfs_pkg::RS_NONE;
      end
    endcase
    return sel;
  endfunction

  // Every pin and analog comparator comes from outside the clock domain.
  always_comb begin
    pin_raw = '0;
    pin_raw[dfs_pkg::PIN_EN] = switch_enable;
    pin_raw[dfs_pkg::PIN_DIAG] = diag_enable;
    pin_raw[dfs_pkg::PIN_SEL_HI] = sense_select_hi;
    pin_raw[dfs_pkg::PIN_SEL_LO] = sense_select_lo;
    pin_raw[dfs_pkg::PIN_LATCH] = latch_mode;
    pin_raw[dfs_pkg::PIN_OVERCUR] = overcurrent_trip;
    pin_raw[dfs_pkg::PIN_THERMAL] = thermal_trip;
    pin_raw[dfs_pkg::PIN_ENERGY] = energy_trip;
    pin_raw[dfs_pkg::PIN_ABOVE_OPENLOAD] = vout_above_openload;
    pin_raw[dfs_pkg::PIN_NEAR_SUPPLY] = vout_near_supply;
  end

  dfs_pin_sync u_sync (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .pin_async (pin_raw),
    .pin_sync  (pin)
  );

  dfs_retry_timer #(
    .TERMINAL (RETRY_CYCLES)
  ) u_retry (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .start   (timer_start),
    .done    (timer_done)
  );

  always_comb begin
    logic                    p_en;
    logic                    p_diag;
    logic                    p_latch;
    logic                    p_oc;
    logic                    regulate;
    logic                    hard_trip;
    logic                    shut_trip;
    logic                    en_rise;
    logic                    diag_fall;
    logic [1:0]              sel;
    logic                    fault_detect;
    logic                    on_next;
    logic [dfs_pkg::IRQ_W-1:0] events;
    logic [dfs_pkg::IRQ_W-1:0] rd_clear;
    logic                    setup;
    logic                    access;
    dfs_pkg::dfs_regsel_type rsel;
    p_en = pin[dfs_pkg::PIN_EN];
    p_diag = pin[dfs_pkg::PIN_DIAG];
    p_latch = pin[dfs_pkg::PIN_LATCH];
    p_oc = pin[dfs_pkg::PIN_OVERCUR];
    regulate = cur_ff.ctrl[dfs_pkg::CTRL_REGULATE_BIT];
    hard_trip = pin[dfs_pkg::PIN_THERMAL] | pin[dfs_pkg::PIN_ENERGY];
    // Regulating parts ride through overcurrent; the others shut off.
    shut_trip = hard_trip | (p_oc & ~regulate);
    en_rise = p_en & ~cur_ff.prev_en;
    diag_fall = ~p_diag & cur_ff.prev_diag;
    sel = {pin[dfs_pkg::PIN_SEL_HI], pin[dfs_pkg::PIN_SEL_LO]};
    events = '0;
    timer_start = 1'b0;
    nxt_ff = cur_ff;
    nxt_ff.prev_en = p_en;
    nxt_ff.prev_diag = p_diag;

    case (cur_ff.state)
      dfs_pkg::S_IDLE: begin
        if (p_en) begin
          nxt_ff.state = dfs_pkg::S_ACTIVE;
        end
      end
      dfs_pkg::S_ACTIVE: begin
        if (shut_trip) begin
          nxt_ff.state = dfs_pkg::S_FAULT;
          timer_start = 1'b1;
        end else if (!p_en) begin
          nxt_ff.state = dfs_pkg::S_IDLE;
        end
      end
      dfs_pkg::S_FAULT: begin
        // A held latch input or any lasting trip keeps the switch off.
        if (!hard_trip && !p_oc && !p_latch && timer_done) begin
          if (p_en) begin
            nxt_ff.state = dfs_pkg::S_RETRY;
          end else begin
            nxt_ff.state = dfs_pkg::S_IDLE;
          end
        end
      end
      dfs_pkg::S_RETRY: begin
        if (shut_trip) begin
          nxt_ff.state = dfs_pkg::S_FAULT;
          timer_start = 1'b1;
        end else if (!p_en) begin
          nxt_ff.state = dfs_pkg::S_IDLE;
        end else if (pin[dfs_pkg::PIN_NEAR_SUPPLY]) begin
          // A shorted load never rises near supply, so the state stays in retry until a trip or a disable.
          nxt_ff.state = dfs_pkg::S_ACTIVE;
          events[dfs_pkg::IRQ_RETRY_BIT] = 1'b1;
        end
      end
      default: begin
        nxt_ff.state = dfs_pkg::S_IDLE;
      end
    endcase

    on_next = (nxt_ff.state == dfs_pkg::S_ACTIVE) ||
              (nxt_ff.state == dfs_pkg::S_RETRY);
    nxt_ff.switch_on = on_next;
    nxt_ff.limiting = on_next & regulate & p_oc;
    nxt_ff.det_en = p_diag & ~p_en;
    nxt_ff.offstate = nxt_ff.det_en & pin[dfs_pkg::PIN_ABOVE_OPENLOAD] &
                      ~(diag_fall | en_rise);

    // Retry is not counted here, so the status line frees on re-enable.
    fault_detect = (nxt_ff.state == dfs_pkg::S_FAULT) | nxt_ff.limiting |
                   (nxt_ff.offstate & (sel == dfs_pkg::SEL_LOAD) &
                    ~on_next);
    nxt_ff.fault_low = fault_detect;

    if (!p_diag) begin
      nxt_ff.route = dfs_pkg::RT_OFF;
    end else begin
      case (sel)
        dfs_pkg::SEL_LOAD: begin
          if (fault_detect || nxt_ff.state == dfs_pkg::S_RETRY) begin
            nxt_ff.route = dfs_pkg::RT_FAULT;
          end else begin
            nxt_ff.route = dfs_pkg::RT_LOAD;
          end
        end
        dfs_pkg::SEL_TEMP: begin
          nxt_ff.route = dfs_pkg::RT_TEMP;
        end
        dfs_pkg::SEL_SUPPLY: begin
          nxt_ff.route = dfs_pkg::RT_SUPPLY;
        end
        default: begin
          nxt_ff.route = dfs_pkg::RT_OFF;
        end
      endcase
    end

    events[dfs_pkg::IRQ_SHUTDOWN_BIT] = timer_start;
    events[dfs_pkg::IRQ_LIMIT_BIT] = nxt_ff.limiting & ~cur_ff.limiting;
    events[dfs_pkg::IRQ_OFFSTATE_BIT] = nxt_ff.offstate & ~cur_ff.offstate;

    // Zero-wait slave: read data is captured in setup, used in access.
    setup = psel & ~penable;
    access = psel & penable;
    rsel = dfs_decode(paddr);
    rd_clear = '0;
    if (setup) begin
      nxt_ff.err = (rsel == dfs_pkg::RS_NONE);
      nxt_ff.rdata = '0;
      case (rsel)
        dfs_pkg::RS_CTRL: begin
          nxt_ff.rdata[dfs_pkg::CTRL_W-1:0] = cur_ff.ctrl;
        end
        dfs_pkg::RS_STATUS: begin
          nxt_ff.rdata[dfs_pkg::STAT_STATE_LSB +: 2] = cur_ff.state;
          nxt_ff.rdata[dfs_pkg::STAT_SWITCH_BIT] = cur_ff.switch_on;
          nxt_ff.rdata[dfs_pkg::STAT_LIMIT_BIT] = cur_ff.limiting;
          nxt_ff.rdata[dfs_pkg::STAT_OFFSTATE_BIT] = cur_ff.offstate;
          nxt_ff.rdata[dfs_pkg::STAT_FAULT_BIT] = cur_ff.fault_low;
          nxt_ff.rdata[dfs_pkg::STAT_DETEN_BIT] = cur_ff.det_en;
        end
        dfs_pkg::RS_ISTAT: begin
          nxt_ff.rdata[dfs_pkg::IRQ_W-1:0] = cur_ff.irq_stat;
        end
        dfs_pkg::RS_IMASK: begin
          nxt_ff.rdata[dfs_pkg::IRQ_W-1:0] = cur_ff.irq_mask;
        end
        default: begin
          nxt_ff.rdata = '0;
        end
      endcase
    end
    if (access && pwrite) begin
      if (rsel == dfs_pkg::RS_CTRL) begin
        nxt_ff.ctrl = pwdata[dfs_pkg::CTRL_W-1:0];
      end
      if (rsel == dfs_pkg::RS_IMASK) begin
        nxt_ff.irq_mask = pwdata[dfs_pkg::IRQ_W-1:0];
      end
    end
    if (access && !pwrite && rsel == dfs_pkg::RS_ISTAT) begin
      rd_clear = cur_ff.rdata[dfs_pkg::IRQ_W-1:0];
    end
    // Clearing only what was read, and letting a new event win.
    nxt_ff.irq_stat = (cur_ff.irq_stat & ~rd_clear) | events;
    nxt_ff.irq = |(nxt_ff.irq_stat & nxt_ff.irq_mask);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign switch_on = cur_ff.switch_on;
  assign current_limit_active = cur_ff.limiting;
  assign offstate_detect_en = cur_ff.det_en;
  assign open_load_flag = cur_ff.offstate;
  assign sense_output_en = (cur_ff.route != dfs_pkg::RT_OFF);
  assign sense_output = cur_ff.route;
  // Open drain: the pin is only ever pulled low, never driven high.
  assign fault_status_n_o = 1'b0;
  assign fault_status_n_oe = cur_ff.fault_low;
  assign irq = cur_ff.irq;
  assign prdata = cur_ff.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & cur_ff.err;

endmodule // dfs_diag_fault_sense
`default_nettype wire

// File: tb/dfs_diag_fault_sense_asserts.sv
// Concurrent checks on the ports of the diagnostic fault sense block.
`timescale 1ns/10ps
`default_nettype none
module dfs_chk (
  input wire logic                   clk_sys,
  input wire logic                   resetn,
  input wire logic                   switch_enable,
  input wire logic                   diag_enable,
  input wire logic                   sense_select_hi,
  input wire logic                   sense_select_lo,
  input wire logic                   thermal_trip,
  input wire logic                   vout_above_openload,
  input wire logic                   vout_near_supply,
  input wire logic                   switch_on,
  input wire logic                   offstate_detect_en,
  input wire logic                   open_load_flag,
  input wire logic                   sense_output_en,
  input wire dfs_pkg::dfs_route_type sense_output,
  input wire logic                   fault_status_n_o,
  input wire logic                   fault_status_n_oe
);
  // Pins pass a synchroniser, so five steady samples are asked for.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  AST_OD_LOW: assert property (
    fault_status_n_oe |-> !fault_status_n_o)
    else $error("status pin driven high");
  AST_DIAG_OFF_HIZ: assert property (
    (!diag_enable) [*5] |-> !sense_output_en) else $error("sense driven");
  AST_SEL_TEMP: assert property (
    (diag_enable && sense_select_hi && !sense_select_lo) [*5]
    |-> sense_output_en && sense_output == dfs_pkg::RT_TEMP)
    else $error("temperature not routed");
  AST_SEL_SUPPLY: assert property (
    (diag_enable && sense_select_hi && sense_select_lo) [*5]
    |-> sense_output_en && sense_output == dfs_pkg::RT_SUPPLY)
    else $error("supply not routed");
  AST_SEL_UNUSED: assert property (
    (diag_enable && !sense_select_hi && sense_select_lo) [*5]
    |-> !sense_output_en) else $error("unused select drives sense");
  AST_DETECT_ON: assert property (
    (diag_enable && !switch_enable) [*5] |-> offstate_detect_en)
    else $error("detection not enabled");
  AST_NO_OL_ENABLED: assert property (
    switch_enable [*5] |-> !open_load_flag) else $error("flag while on");
  AST_OL_FOLLOWS: assert property (
    (!vout_above_openload) [*5] |-> !open_load_flag)
    else $error("flag stuck");
  AST_OL_DIAG_LOW: assert property (
    (!diag_enable) [*5] |-> !open_load_flag) else $error("flag kept");
  AST_OL_REPORT: assert property (
    (diag_enable && !switch_enable && vout_above_openload
     && !sense_select_hi && !sense_select_lo) [*5]
    |-> open_load_flag && fault_status_n_oe
        && sense_output == dfs_pkg::RT_FAULT) else $error("no open load");
  AST_SHUTDOWN: assert property (
    thermal_trip [*5] |-> !switch_on && fault_status_n_oe)
    else $error("no shutdown");
  AST_RETRY_RELEASE: assert property (
    $rose(switch_on) |-> !fault_status_n_oe) else $error("status held");
  AST_RETRY_HOLD: assert property (
    ($rose(switch_on) && sense_output == dfs_pkg::RT_FAULT
     && !vout_near_supply) ##1 (!vout_near_supply) [*3]
    |-> sense_output == dfs_pkg::RT_FAULT) else $error("fault dropped");
endmodule // dfs_chk
bind dfs_diag_fault_sense dfs_chk dfs_chk_i (
  .clk_sys, .resetn, .switch_enable, .diag_enable, .sense_select_hi,
  .sense_select_lo, .thermal_trip, .vout_above_openload, .vout_near_supply,
  .switch_on, .offstate_detect_en, .open_load_flag, .sense_output_en,
  .sense_output, .fault_status_n_o, .fault_status_n_oe
);
`default_nettype wire

// File: tb/dfs_host_model.sv
// Host side of the status and sense pins: pull-up and sense resistor.
`timescale 1ns/10ps
`default_nettype none
module dfs_host_model (
  input  wire logic                   fault_status_n_o,
  input  wire logic                   fault_status_n_oe,
  input  wire logic                   sense_output_en,
  input  wire dfs_pkg::dfs_route_type sense_output,
  output logic                        status_pin,
  output dfs_pkg::dfs_route_type      sense_seen
);
  // A released open-drain line floats up to the pull-up level.
  assign status_pin = fault_status_n_oe ? fault_status_n_o : 1'b1;
  // The sense resistor pulls an undriven pin to ground, seen as no route.
  assign sense_seen = sense_output_en ? sense_output : dfs_pkg::RT_OFF;
endmodule // dfs_host_model
`default_nettype wire

// File: tb/tb_diag_fault_sense_mux.sv
// Self-checking bench for the diagnostic fault sense block.
`timescale 1ns/10ps
`default_nettype none
module tb_diag_fault_sense_mux;
  localparam int unsigned RT = 8;
  typedef struct packed {
    logic [4:0]             pins;
    dfs_pkg::dfs_route_type rt;
    logic                   st;
    logic                   on;
  } dfs_row_type;
  // Pins are {diag, select hi, select lo, enable, above threshold}.
  localparam dfs_row_type ROWS [10] = '{
    '{5'h00, dfs_pkg::RT_OFF, 1'b1, 1'b0},
    '{5'h12, dfs_pkg::RT_LOAD, 1'b1, 1'b1},
    '{5'h1a, dfs_pkg::RT_TEMP, 1'b1, 1'b1},
    '{5'h1e, dfs_pkg::RT_SUPPLY, 1'b1, 1'b1},
    '{5'h16, dfs_pkg::RT_OFF, 1'b1, 1'b1},
    '{5'h11, dfs_pkg::RT_FAULT, 1'b0, 1'b0},
    '{5'h19, dfs_pkg::RT_TEMP, 1'b1, 1'b0},
    '{5'h01, dfs_pkg::RT_OFF, 1'b1, 1'b0},
    '{5'h10, dfs_pkg::RT_LOAD, 1'b1, 1'b0},
    '{5'h13, dfs_pkg::RT_LOAD, 1'b1, 1'b1}
  };
  logic clk_sys, resetn, switch_enable, diag_enable, latch_mode;
  logic sense_select_hi, sense_select_lo, overcurrent_trip, thermal_trip;
  logic energy_trip, vout_above_openload, vout_near_supply;
  logic psel, penable, pwrite, pready, pslverr, irq, status_pin;
  logic switch_on, current_limit_active, offstate_detect_en;
  logic open_load_flag, sense_output_en, fault_status_n_o, fault_status_n_oe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  dfs_pkg::dfs_route_type sense_output, sense_seen;
  int n_errors, n_tests;

  dfs_diag_fault_sense #(.RETRY_CYCLES(RT)) dfs_diag_fault_sense_i (
    .clk_sys, .resetn, .switch_enable, .diag_enable, .sense_select_hi,
    .sense_select_lo, .latch_mode, .overcurrent_trip, .thermal_trip,
    .energy_trip, .vout_above_openload, .vout_near_supply, .switch_on,
    .current_limit_active, .offstate_detect_en, .open_load_flag,
    .sense_output_en, .sense_output, .fault_status_n_o, .fault_status_n_oe,
    .irq, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr
  );
  dfs_host_model dfs_host_model_i (
    .fault_status_n_o, .fault_status_n_oe, .sense_output_en, .sense_output,
    .status_pin, .sense_seen
  );

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Holds the request until pready is sampled high with penable.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x,
                    input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk("rdata", x, r);
    chk("pslverr", 32'(xe), 32'(e));
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic test_done;
    $display("errors %0d of %0d checks", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Whole run is a few hundred cycles; this limit only catches a hang.
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_errors++;
    test_done();
  end

  initial begin
    n_errors = 0;
    n_tests = 0;
    resetn = 1'b0;
    {switch_enable, diag_enable, sense_select_hi, sense_select_lo} = 4'h0;
    {latch_mode, overcurrent_trip, thermal_trip, energy_trip} = 4'h0;
    {vout_above_openload, vout_near_supply, psel, penable, pwrite} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (16) @(posedge clk_sys);
    chk("reset outputs", 32'h0000_0000, prdata |
        32'({switch_on, fault_status_n_oe, sense_output_en, irq}));
    chk("reset pready", 32'h0000_0001, 32'(pready));
    resetn <= 1'b1;
    rd(dfs_pkg::ADDR_CTRL, 32'h0000_0000, 1'b0);
    rd(dfs_pkg::ADDR_STATUS, 32'h0000_0000, 1'b0);
    rd(dfs_pkg::ADDR_IRQ_STAT, 32'h0000_0000, 1'b0);
    rd(dfs_pkg::ADDR_IRQ_MASK, 32'h0000_0000, 1'b0);
    wr(12'h010, 32'hffff_ffff);
    rd(12'h010, 32'h0000_0000, 1'b1);
    foreach (ROWS[i]) begin
      @(posedge clk_sys);
      {diag_enable, sense_select_hi, sense_select_lo, switch_enable,
       vout_above_openload} <= ROWS[i].pins;
      vout_near_supply <= ROWS[i].pins[1];
      cyc(6);
      chk("sense", 32'(ROWS[i].rt), 32'(sense_seen));
      chk("status", 32'(ROWS[i].st), 32'(status_pin));
      chk("switch", 32'(ROWS[i].on), 32'(switch_on));
    end
    chk("irq masked", 32'h0000_0000, 32'(irq));
    wr(dfs_pkg::ADDR_IRQ_MASK, 32'h0000_000f);
    rd(dfs_pkg::ADDR_IRQ_MASK, 32'h0000_000f, 1'b0);
    chk("irq raised", 32'h0000_0001, 32'(irq));
    rd(dfs_pkg::ADDR_IRQ_STAT, 32'h0000_0004, 1'b0);
    cyc(3);
    chk("irq cleared", 32'h0000_0000, 32'(irq));
    // Immediate variant: overcurrent shutdown held by the latch input.
    vout_above_openload <= 1'b0;
    latch_mode <= 1'b1;
    overcurrent_trip <= 1'b1;
    cyc(6);
    chk("trip off", 32'h0000_0000, 32'(switch_on));
    chk("trip status", 32'h0000_0000, 32'(status_pin));
    chk("trip sense", 32'(dfs_pkg::RT_FAULT), 32'(sense_seen));
    chk("trip irq", 32'h0000_0001, 32'(irq));
    diag_enable <= 1'b0;
    cyc(6);
    chk("diag off status", 32'h0000_0000, 32'(status_pin));
    chk("diag off sense", 32'(dfs_pkg::RT_OFF), 32'(sense_seen));
    diag_enable <= 1'b1;
    overcurrent_trip <= 1'b0;
    cyc(RT + 10);
    chk("latched", 32'h0000_0000, 32'(switch_on));
    vout_near_supply <= 1'b0;
    latch_mode <= 1'b0;
    cyc(8);
    chk("retry on", 32'h0000_0001, 32'(switch_on));
    chk("retry status", 32'h0000_0001, 32'(status_pin));
    chk("retry sense", 32'(dfs_pkg::RT_FAULT), 32'(sense_seen));
    cyc(20);
    chk("short sense", 32'(dfs_pkg::RT_FAULT), 32'(sense_seen));
    vout_near_supply <= 1'b1;
    cyc(6);
    chk("risen sense", 32'(dfs_pkg::RT_LOAD), 32'(sense_seen));
    rd(dfs_pkg::ADDR_IRQ_STAT, 32'h0000_0009, 1'b0);
    // Regulating variant: limiting keeps the switch on until thermal trips.
    wr(dfs_pkg::ADDR_CTRL, 32'h0000_0001);
    rd(dfs_pkg::ADDR_CTRL, 32'h0000_0001, 1'b0);
    overcurrent_trip <= 1'b1;
    cyc(6);
    chk("limit on", 32'h0000_0001, 32'(switch_on));
    chk("limiting", 32'h0000_0001, 32'(current_limit_active));
    chk("limit status", 32'h0000_0000, 32'(status_pin));
    chk("limit sense", 32'(dfs_pkg::RT_FAULT), 32'(sense_seen));
    thermal_trip <= 1'b1;
    energy_trip <= 1'b1;
    cyc(5);
    {overcurrent_trip, thermal_trip, energy_trip} <= 3'h0;
    cyc(3);
    chk("hot off", 32'h0000_0000, 32'(switch_on));
    cyc(RT + 10);
    chk("hot retry", 32'h0000_0001, 32'(switch_on));
    chk("limit end", 32'h0000_0000, 32'(current_limit_active));
    test_done();
  end
endmodule // tb_diag_fault_sense_mux
`default_nettype wire
